//--- verilog/mafe_pkg.sv
// shared constants and types of the motion front end control block
package mafe_pkg;
   // system clock rate
   localparam int unsigned CLK_HZ   = 100_000_000;
   // channels: eight inputs plus temperature-voltage
   localparam int unsigned NCH      = 9;
   // converter resolution in bits
   localparam int unsigned RES_W    = 12;
   // recovery count loaded by any reset; ready rises one clock after it reaches zero
   localparam logic [1:0]  SRST_CNT = 2'h1;
   // sample divider: reset value, fastest and slowest setting
   localparam logic [12:0] RATE_RST = 13'h0800;
   localparam logic [12:0] RATE_MIN = 13'h0100;
   localparam logic [12:0] RATE_MAX = 13'h1000;
   // wishbone byte offsets
   localparam logic [7:0]  ADR_RATE = 8'h00;
   localparam logic [7:0]  ADR_STAT = 8'h04;
   localparam logic [7:0]  ADR_FILT = 8'h08;
   localparam logic [7:0]  ADR_RES  = 8'h40;
   // status field positions above the channel enables
   localparam int unsigned ST_BUSY  = 9;
   localparam int unsigned ST_RDY   = 10;
   localparam int unsigned ST_MEAS  = 11;
   localparam int unsigned ST_REG   = 12;
   // filter codes per channel group
   localparam logic [1:0]  FLT_250  = 2'h0;
   localparam logic [1:0]  FLT_125  = 2'h1;
   localparam logic [1:0]  FLT_BYP  = 2'h2;
   // command decoder states
   typedef enum logic [2:0] {
      CM_IDLE = 3'h0,
      CM_P1   = 3'h1,
      CM_P2   = 3'h2,
      CM_READ = 3'h3,
      CM_SKIP = 3'h4
   } mafe_cm_t;
endpackage : mafe_pkg

//--- verilog/mafe_spi_byte.sv
// serial byte engine: mode zero, msb first, eight-bit units
module mafe_spi_byte (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       sel_n_i,
   input  wire logic       sclk_i,
   input  wire logic       sdi_i,
   input  wire logic [7:0] tx_byte_i,
   output logic      [7:0] byte_o,
   output logic            byte_vld_o,
   output logic            sdo_o
);
   // whole state of the engine
   typedef struct packed {
      logic       sclk_q;  // previous serial clock level
      logic [2:0] cnt;     // bits taken in this byte
      logic [7:0] sh;      // receive shifter
      logic [7:0] tx;      // transmit shifter
      logic [7:0] rx;      // completed byte
      logic       vld;     // completed byte pulse
   } mafe_sb_t;

   mafe_sb_t s_r;  // registered state
   mafe_sb_t s_nxt;  // next state

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.vld = 1'b0;
      s_nxt.sclk_q = sclk_i;
      if (sel_n_i) begin
         // RL3: idle select ignores
         s_nxt.cnt = 3'h0;
         s_nxt.tx = tx_byte_i;
      end else if (sclk_i && !s_r.sclk_q) begin
         // RL1: rising edge samples
         s_nxt.sh = {s_r.sh[6:0], sdi_i};
         s_nxt.cnt = s_r.cnt + 3'h1;
         if (s_r.cnt == 3'h7) begin
            // RL22: eighth bit completes
            s_nxt.rx = {s_r.sh[6:0], sdi_i};
            s_nxt.vld = 1'b1;
         end
      end else if (!sclk_i && s_r.sclk_q) begin
         // falling edge moves next bit out
         if (s_r.cnt == 3'h0) begin
            s_nxt.tx = tx_byte_i;
         end else begin
            s_nxt.tx = {s_r.tx[6:0], 1'b0};
         end
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign byte_o = s_r.rx;
   assign byte_vld_o = s_r.vld;
   assign sdo_o = s_r.tx[7];

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   bit_cancel_a: assert property (sel_n_i |=> s_r.cnt == 3'h0) // RL23
      else $error("bit counter not cleared by idle select");
   byte_eight_a: assert property ( // RL22
      (!sel_n_i && sclk_i && !s_r.sclk_q && s_r.cnt == 3'h7)
      |=> byte_vld_o)
      else $error("byte not completed on eighth bit");
endmodule // mafe_spi_byte

//--- verilog/mafe_rate_tick.sv
// sample rate divider: one tick every div_i clocks
module mafe_rate_tick (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        en_i,
   input  wire logic [12:0] div_i,
   output logic             tick_o
);
   // whole state of the divider
   typedef struct packed {
      logic [12:0] cnt;  // clocks into the period
      logic        tick; // period end pulse
   } mafe_rt_t;

   mafe_rt_t s_r;  // registered state
   mafe_rt_t s_nxt;  // next state

   ////////////////////////////////////////////////////////////////////
   // RL18: clock over divider
   always_comb begin
      s_nxt = s_r;
      s_nxt.tick = 1'b0;
      if (!en_i) begin
         s_nxt.cnt = 13'h0;
      end else if (s_r.cnt >= div_i - 13'h1) begin
         s_nxt.cnt = 13'h0;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.cnt = s_r.cnt + 13'h1;
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_o = s_r.tick;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   rate_gap_a: assert property (tick_o |=> !tick_o [*8]) // RL18
      else $error("sample ticks too close");
endmodule // mafe_rate_tick

//--- verilog/mafe_ctrl.sv
// motion front end host control: serial commands, sampling, wishbone

////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: mode zero serial, eight-bit units
// RL2: host keeps serial clock at 10 MHz
// RL3: serial input taken only while selected
// RL4: serial output undriven while deselected
// RL5: ready high after reset outside measurement
// RL6: ready high when new results stored
// RL7: host sends software reset first
// RL8: host waits three clocks after reset
// RL9: ready rises when reset completes
// RL10: measurement setting enables channels
// RL11: filter setting per group: 250, 125, bypass
// RL12: regulator commands only when not disabled
// RL13: host waits 500 ms after regulator on
// RL14: start enables sampling, ready goes low
// RL15: host reads before ready falls
// RL16: single or continuous channel reads
// RL17: stop disables sampling
// RL18: sample rate is clock over divider
// RL19: divider range gives 0.5 to 8 kHz; at the 100 MHz clock the 256 to 4096 divider gives 24.4 to 390.6 kHz
// RL20: twelve-bit results from one converter
// RL21: one result register per channel
// RL22: msb first, excess bytes ignored
// RL23: deselect cancels byte, clears bit count
// RL24: fixed channel order, disabled skipped
// RL25: command codes are parameters
module mafe_ctrl #(
   // RL25: command codes
   parameter logic [7:0]  CMD_SRST   = 8'h01,
   parameter logic [7:0]  CMD_MSET   = 8'h02,
   parameter logic [7:0]  CMD_FILT   = 8'h03,
   parameter logic [7:0]  CMD_REGON  = 8'h04,
   parameter logic [7:0]  CMD_REGOFF = 8'h05,
   parameter logic [7:0]  CMD_START  = 8'h06,
   parameter logic [7:0]  CMD_STOP   = 8'h07,
   parameter logic [7:0]  CMD_READ   = 8'h08,
   parameter logic [7:0]  CMD_CREAD  = 8'h09,
   parameter int unsigned DEPTH      = 1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // serial link from the host
   input  wire logic        serial_select_n_i,
   input  wire logic        sclk_i,
   input  wire logic        sdi_i,
   output logic             sdo_o,
   output logic             sdo_oe_o,
   output logic             result_ready_o,
   // analog side
   input  wire logic        analog_regulator_disable_i,
   output logic             regulator_en_o,
   output logic             sampling_en_o,
   output logic      [9:0]  filter_sel_o,
   output logic             adc_start_o,
   output logic      [3:0]  adc_chan_o,
   input  wire logic        adc_done_i,
   input  wire logic [11:0] adc_result_i
);
   localparam logic [3:0] NONE = 4'(mafe_pkg::NCH);

   // RL21: only one register per channel is built
   if (DEPTH != 1) begin : g_depth_chk
      $error("only one result register per channel is built");
   end

   ////////////////////////////////////////////////////////////////////
   // whole state of the block
   typedef struct packed {
      mafe_pkg::mafe_cm_t cm;        // command decoder state
      logic [7:0]         op;        // command being served
      logic [7:0]         par;       // first parameter byte
      logic [8:0]         chan_en;   // channel enables
      logic [9:0]         filt;      // filter codes per group
      logic               reg_on;    // regulator commanded on
      logic               reg_en;    // regulator actually enabled
      logic               meas;      // measurement running
      logic               rdy;       // ready output
      logic               busy;      // reset recovery
      logic [1:0]         srst_cnt;  // recovery count
      logic               conv;      // sample set in progress
      logic               go;        // converter start pulse
      logic [3:0]         cch;       // channel converting
      logic [3:0]         rch;       // channel being read
      logic               rhi;       // next byte is high half
      logic               cont;      // continuous read
      logic [7:0]         txb;       // next byte to send
      logic [12:0]        rate;      // sample divider
      logic               ack;       // bus acknowledge
      logic [31:0]        dat;       // bus read data
      logic [8:0][11:0]   res;       // RL20: result registers
   } mafe_st_t;

   // reset image: recovery runs, then ready rises
   localparam mafe_st_t RST_S = '{
      cm:       mafe_pkg::CM_IDLE,
      rate:     mafe_pkg::RATE_RST,
      busy:     1'b1,
      srst_cnt: mafe_pkg::SRST_CNT,
      default:  '0
   };

   mafe_st_t   s_r;       // registered state
   mafe_st_t   s_nxt;     // next state
   logic [7:0] rx_byte;   // byte from the host
   logic       rx_vld;    // byte complete pulse
   logic       tx_bit;    // serial output bit
   logic       tick;      // sample period pulse

   ////////////////////////////////////////////////////////////////////
   // first enabled channel at or after a given one
   function automatic logic [3:0] next_ch(input logic [3:0] from,
                                          input logic [8:0] en);
      logic [3:0] r;
      r = NONE;
      for (int i = 8; i >= 0; i--) begin
         if (4'(i) >= from && en[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // stored result, zero for a channel that does not exist
   function automatic logic [11:0] res_at(input mafe_st_t st,
                                          input logic [3:0] i);
      logic [11:0] r;
      r = '0;
      if (i < NONE) begin
         r = st.res[i];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // serial byte engine
   mafe_spi_byte u_spi (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .sel_n_i    (serial_select_n_i),
      .sclk_i     (sclk_i),
      .sdi_i      (sdi_i),
      .tx_byte_i  (s_r.txb),
      .byte_o     (rx_byte),
      .byte_vld_o (rx_vld),
      .sdo_o      (tx_bit)
   );

   // sample period timer, runs only while measuring
   mafe_rate_tick u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .en_i   (s_r.meas),
      .div_i  (s_r.rate),
      .tick_o (tick)
   );

   ////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      logic [3:0]  nx;
      logic [12:0] w;
      logic [31:0] rd;
      logic        srst;
      logic [11:0] rv;  // stored result being sent
      nx = '0;
      w = '0;
      rd = '0;
      srst = 1'b0;
      rv = '0;
      s_nxt = s_r;
      s_nxt.go = 1'b0;
      s_nxt.ack = 1'b0;

      // reset recovery countdown
      if (s_r.busy) begin
         if (s_r.srst_cnt == 2'h0) begin
            s_nxt.busy = 1'b0;
            // RL5: ready once reset is over
            s_nxt.rdy = !s_r.meas;
         end else begin
            s_nxt.srst_cnt = s_r.srst_cnt - 2'h1;
         end
      end

      // sample set sequencer
      if (s_r.meas) begin
         if (tick && !s_r.conv) begin
            // RL24: first enabled channel
            nx = next_ch(4'h0, s_r.chan_en);
            s_nxt.rdy = (nx == NONE);
            if (nx != NONE) begin
               s_nxt.conv = 1'b1;
               s_nxt.cch = nx;
               s_nxt.go = 1'b1;
            end
         end else if (s_r.conv && adc_done_i) begin
            s_nxt.res[s_r.cch] = adc_result_i;
            // RL24: skip disabled channels
            nx = next_ch(s_r.cch + 4'h1, s_r.chan_en);
            if (nx == NONE) begin
               // RL6: set stored, ready rises
               s_nxt.conv = 1'b0;
               s_nxt.rdy = 1'b1;
            end else begin
               s_nxt.cch = nx;
               s_nxt.go = 1'b1;
            end
         end
      end

      // RL3: bytes count only while selected
      if (rx_vld && !serial_select_n_i) begin
         unique case (s_r.cm)
            mafe_pkg::CM_IDLE: begin
               s_nxt.op = rx_byte;
               if (rx_byte == CMD_SRST) begin
                  srst = 1'b1;
               end else if (rx_byte == CMD_MSET ||
                            rx_byte == CMD_FILT ||
                            rx_byte == CMD_READ) begin
                  s_nxt.cm = mafe_pkg::CM_P1;
               end else if (rx_byte == CMD_REGON) begin
                  // RL12: no effect while the pin disables it
                  s_nxt.reg_on = s_r.reg_on || !analog_regulator_disable_i;
               end else if (rx_byte == CMD_REGOFF) begin
                  s_nxt.reg_on = s_r.reg_on && analog_regulator_disable_i;
               end else if (rx_byte == CMD_START) begin
                  // RL14: sampling on, ready low
                  s_nxt.meas = 1'b1;
                  s_nxt.conv = 1'b0;
                  s_nxt.rdy = 1'b0;
               end else if (rx_byte == CMD_STOP) begin
                  // RL17: sampling off
                  s_nxt.meas = 1'b0;
                  s_nxt.conv = 1'b0;
                  s_nxt.go = 1'b0;
                  s_nxt.rdy = !s_r.busy;
               end else if (rx_byte == CMD_CREAD) begin
                  // RL16: continuous read from first
                  s_nxt.cont = 1'b1;
                  s_nxt.rch = 4'h0;
                  s_nxt.rhi = 1'b1;
                  s_nxt.txb = {4'h0, s_r.res[0][11:8]};
                  s_nxt.cm = mafe_pkg::CM_READ;
               end
            end
            mafe_pkg::CM_P1: begin
               s_nxt.par = rx_byte;
               if (s_r.op == CMD_READ) begin
                  // RL16: single channel read
                  s_nxt.cont = 1'b0;
                  s_nxt.rch = rx_byte[3:0];
                  s_nxt.rhi = 1'b1;
                  rv = res_at(s_r, rx_byte[3:0]);
                  s_nxt.txb = {4'h0, rv[11:8]};
                  s_nxt.cm = mafe_pkg::CM_READ;
               end else begin
                  s_nxt.cm = mafe_pkg::CM_P2;
               end
            end
            mafe_pkg::CM_P2: begin
               if (s_r.op == CMD_MSET) begin
                  // RL10: channel enables
                  s_nxt.chan_en = {s_r.par[0], rx_byte};
               end else begin
                  // RL11: filter code per group
                  s_nxt.filt = {s_r.par[1:0], rx_byte};
               end
               s_nxt.cm = mafe_pkg::CM_SKIP;
            end
            mafe_pkg::CM_READ: begin
               if (s_r.rhi) begin
                  rv = res_at(s_r, s_r.rch);
                  s_nxt.txb = rv[7:0];
                  s_nxt.rhi = 1'b0;
               end else if (s_r.cont && s_r.rch < 4'h8) begin
                  s_nxt.rch = s_r.rch + 4'h1;
                  s_nxt.rhi = 1'b1;
                  rv = res_at(s_r, s_r.rch + 4'h1);
                  s_nxt.txb = {4'h0, rv[11:8]};
               end else begin
                  s_nxt.txb = 8'h00;
                  s_nxt.cm = mafe_pkg::CM_SKIP;
               end
            end
            // RL22: excess bytes ignored
            mafe_pkg::CM_SKIP: begin
               s_nxt.cm = mafe_pkg::CM_SKIP;
            end
         endcase
      end

      // RL23: deselect ends the command and any read
      if (serial_select_n_i) begin
         s_nxt.cm = mafe_pkg::CM_IDLE;
         s_nxt.txb = 8'h00;
      end

      // software reset restarts from the reset image
      if (srst) begin
         s_nxt = RST_S;
      end

      // bus read data, captured when the request arrives
      if (wb_adr_i == mafe_pkg::ADR_RATE) begin
         rd[12:0] = s_r.rate;
      end else if (wb_adr_i == mafe_pkg::ADR_STAT) begin
         rd[8:0] = s_r.chan_en;
         rd[mafe_pkg::ST_BUSY] = s_r.busy;
         rd[mafe_pkg::ST_RDY] = s_r.rdy;
         rd[mafe_pkg::ST_MEAS] = s_r.meas;
         rd[mafe_pkg::ST_REG] = s_r.reg_en;
      end else if (wb_adr_i == mafe_pkg::ADR_FILT) begin
         rd[9:0] = s_r.filt;
      end else if (wb_adr_i[7:6] == mafe_pkg::ADR_RES[7:6]) begin
         rd[11:0] = res_at(s_r, wb_adr_i[5:2]);
      end
      if (wb_cyc_i && wb_stb_i && !s_r.ack) begin
         s_nxt.ack = 1'b1;
         s_nxt.dat = rd;
      end

      // RL19: divider write at the acknowledging edge, clamped
      if (s_r.ack && wb_cyc_i && wb_stb_i && wb_we_i &&
          wb_adr_i == mafe_pkg::ADR_RATE) begin
         w = s_r.rate;
         if (wb_sel_i[0]) begin
            w[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            w[12:8] = wb_dat_i[12:8];
         end
         if (w < mafe_pkg::RATE_MIN) begin
            w = mafe_pkg::RATE_MIN;
         end else if (w > mafe_pkg::RATE_MAX) begin
            w = mafe_pkg::RATE_MAX;
         end
         s_nxt.rate = w;
      end

      // RL12: regulator follows command only when allowed
      s_nxt.reg_en = s_nxt.reg_on && !analog_regulator_disable_i;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= RST_S;
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   // RL4: output enabled only while selected
   assign sdo_oe_o = !serial_select_n_i;
   assign sdo_o = tx_bit && !serial_select_n_i;
   assign result_ready_o = s_r.rdy;
   assign regulator_en_o = s_r.reg_en;
   assign sampling_en_o = s_r.meas;
   assign filter_sel_o = s_r.filt;
   assign adc_start_o = s_r.go;
   assign adc_chan_o = s_r.cch;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic cmd_vld;  // a command byte taken in idle
   assign cmd_vld = rx_vld && !serial_select_n_i &&
                    s_r.cm == mafe_pkg::CM_IDLE;

   sequence recover_s;
      !result_ready_o [*2] ##1 result_ready_o;
   endsequence

   sdo_quiet_a: assert property ( // RL4
      serial_select_n_i |-> !sdo_oe_o && !sdo_o)
      else $error("serial output driven while deselected");
   reset_ready_a: assert property ( // RL9
      (cmd_vld && rx_byte == CMD_SRST) |=> recover_s)
      else $error("ready not raised after software reset");
   start_low_a: assert property ( // RL14
      (cmd_vld && rx_byte == CMD_START) |=>
      !result_ready_o && sampling_en_o)
      else $error("start did not drop ready");
   stop_quiet_a: assert property ( // RL17
      (cmd_vld && rx_byte == CMD_STOP) |=> !adc_start_o [*4])
      else $error("conversion after stop");
   conv_order_a: assert property ( // RL24
      adc_start_o |-> s_r.chan_en[adc_chan_o] && adc_chan_o < NONE)
      else $error("disabled channel converted");
   ready_done_a: assert property ( // RL6
      (sampling_en_o && $rose(result_ready_o)) |-> !s_r.conv)
      else $error("ready before sample set done");
   reg_gate_a: assert property ( // RL12
      analog_regulator_disable_i |=> !regulator_en_o)
      else $error("regulator on while disabled");
endmodule // mafe_ctrl

//--- testbench/mafe_host_model.sv
// host model: mode-zero serial master driving the control block
module mafe_host_model (
   input  wire logic clk_i,
   input  wire logic sdo_i,
   output logic      sel_n_o,
   output logic      sclk_o,
   output logic      sdi_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle: deselected, serial clock resting low
   initial begin
      sel_n_o = 1'b1;
      sclk_o  = 1'b0;
      sdi_o   = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////
   // msb first, five clocks a phase
   task automatic shift(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sdi_o <= tx[i];
         repeat (5) @(posedge clk_i);
         sclk_o <= 1'b1;
         rx[i] = sdo_i;
         repeat (5) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
   endtask
   // frame edge; a released data line flips
   task automatic frame(input logic open);
      @(posedge clk_i);
      sel_n_o <= ~open;
      if (!open) sdi_o <= ~sdi_o;
      repeat (5) @(posedge clk_i);
   endtask
endmodule // mafe_host_model

//--- testbench/test_mafe_ctrl.sv
// self-checking bench for the front end control block
module test_mafe_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0;
   logic        we = 1'b0, areg_dis = 1'b0, adc_done = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic [3:0]  sel = 4'h0, adc_chan, cur = 4'h0;
   logic        ack, sel_n, sclk, sdi, sdo, sdo_oe, rdy;
   logic        reg_en, samp_en, adc_start;
   logic [9:0]  filt;
   logic [11:0] adc_res = 12'h0;
   logic [15:0] rr;
   logic [3:0]  chq [$];
   int          t0q [$];
   int          cyc_n = 0, dly = 0, n_fail = 0, total_checks = 0;
   always #5 clk = ~clk;
   mafe_ctrl dut (
      .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
      .wb_dat_o(rdat), .wb_ack_o(ack), .serial_select_n_i(sel_n),
      .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
      .result_ready_o(rdy), .analog_regulator_disable_i(areg_dis),
      .regulator_en_o(reg_en), .sampling_en_o(samp_en),
      .filter_sel_o(filt), .adc_start_o(adc_start),
      .adc_chan_o(adc_chan), .adc_done_i(adc_done),
      .adc_result_i(adc_res));
   mafe_host_model host (.clk_i(clk), .sdo_i(sdo), .sel_n_o(sel_n),
      .sclk_o(sclk), .sdi_o(sdi));
   ////////////////////////////////////////////////////////////////////
   // converter model: done three clocks after start, logs order
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      adc_done <= (dly == 1);
      adc_res <= {8'ha5, cur};
      if (adc_start === 1'b1) begin
         chq.push_back(adc_chan);
         if (adc_chan === 4'h0) t0q.push_back(cyc_n);
         dly <= 3;
         cur <= adc_chan;
      end else if (dly != 0) dly <= dly - 1;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   // classic single wishbone cycle, waits for ack
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      // no own limit: the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   // one serial frame; rr keeps the last two reply bytes
   task automatic send(input logic [7:0] b [$]);
      logic [7:0] r;
      host.frame(1'b1);
      foreach (b[i]) begin
         host.shift(b[i], 8, r);
         rr = {rr[7:0], r};
      end
      host.frame(1'b0);
   endtask
   task automatic wait_rdy();
      while (rdy !== 1'b1) @(posedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      wb(1'b0, mafe_pkg::ADR_RATE, 0);
      chk("rate_rst", q, mafe_pkg::RATE_RST);
      wb(1'b1, mafe_pkg::ADR_RATE, 32'h1);
      wb(1'b0, mafe_pkg::ADR_RATE, 0);
      chk("rate_min", q, mafe_pkg::RATE_MIN);
      wb(1'b1, mafe_pkg::ADR_RATE, 32'h1fff);
      wb(1'b0, mafe_pkg::ADR_RATE, 0);
      chk("rate_max", q, mafe_pkg::RATE_MAX);
      wb(1'b0, 8'h3c, 0);
      chk("unmapped", q, 0);
      host.shift(dut.CMD_START, 8, rr[7:0]);
      chk("oe_idle", sdo_oe, 0);
      chk("sdo_idle", sdo, 0);
      chk("desel", samp_en, 0);
      // software reset is the first selected command
      send('{dut.CMD_SRST});
      // poll ready for the end of recovery
      wait_rdy();
      wb(1'b0, mafe_pkg::ADR_RATE, 0);
      chk("srst_rate", q, mafe_pkg::RATE_RST);
   endtask
   task automatic t_cfg();
      send('{dut.CMD_MSET, 8'h01, 8'h05, dut.CMD_START});
      wb(1'b0, mafe_pkg::ADR_STAT, 0);
      chk("chan_en", q[8:0], 9'h105);
      chk("excess", samp_en, 0);
      send('{dut.CMD_FILT, 8'h02, 8'h51});
      chk("filter", filt, 10'h251);
      wb(1'b0, mafe_pkg::ADR_FILT, 0);
      chk("filt_reg", q, 10'h251);
      areg_dis <= 1'b1;
      send('{dut.CMD_REGON});
      chk("reg_dis", reg_en, 0);
      areg_dis <= 1'b0;
      host.frame(1'b1);
      host.shift(dut.CMD_REGON, 4, rr[7:0]);
      host.frame(1'b0);
      chk("cancel", reg_en, 0);
      send('{dut.CMD_REGON});
      chk("reg_on", reg_en, 1);
   endtask
   task automatic t_meas();
      wb(1'b1, mafe_pkg::ADR_RATE, 32'h1000);
      chq.delete();
      t0q.delete();
      // supply settle wait, scaled down to keep the run short
      repeat (100) @(posedge clk);
      send('{dut.CMD_START});
      chk("samp_on", samp_en, 1);
      chk("rdy_low", rdy, 0);
      wait_rdy();
      chk("rdy_set", rdy, 1);
      chk("order", {chq[0], chq[1], chq[2]}, 12'h028);
      // reads end well inside one sample period
      send('{dut.CMD_READ, 8'h02, 8'h00, 8'h00});
      chk("read", rr, 16'h0a52);
      send('{dut.CMD_CREAD, 8'h00, 8'h00});
      chk("cread", rr, 16'h0a50);
      wb(1'b0, mafe_pkg::ADR_RES + 8'h08, 0);
      chk("res_reg", q, 32'ha52);
      while (t0q.size() < 2) @(posedge clk);
      chk("period", t0q[1] - t0q[0], 32'h1000);
      send('{dut.CMD_STOP});
      chk("stop", samp_en, 0);
      chk("rdy_idle", rdy, 1);
      send('{dut.CMD_REGOFF});
      chk("reg_off", reg_en, 0);
   endtask
   // main sequence: reset, then each scenario
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      // ready stays low through this edge of recovery
      @(posedge clk);
      chk("rdy_rec", rdy, 0);
      wait_rdy();
      chk("rdy_rel", rdy, 1);
      t_regs();
      t_cfg();
      t_meas();
      end_sim();
   end
   // watchdog against a hung handshake
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      end_sim();
   end
endmodule // test_mafe_ctrl
